//--- bench/csw_top_tb.sv
// Self-checking testbench of the status word block.
`timescale 1ns/1ps
`include "csw_defs.svh"
module csw_top_tb;
  // ----------------------------------------------------------------------
  // Signals and the design
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] c;
    logic [7:0] a;
    logic [7:0] opn;
    logic [7:0] d;
    logic [3:0] f;
    logic [7:0] ea;
    logic [7:0] eb;
  } csw_row_t;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  csw_pkg::csw_op_t op_i = '0;
  csw_pkg::csw_xacc_t xacc_i = '0;
  logic [7:0] main_work_reg_o;
  logic [7:0] opnd_o;
  csw_pkg::csw_psw_t psw_o;
  logic [7:0] bank_base_o;
  logic xsfr_sel_o;
  logic [`CSW_XOFF_W-1:0] xsfr_off_o;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic [7:0] v;
  csw_row_t r;
  // Flags nibble is {carry in, carry, half-carry, overflow}.
  localparam csw_row_t ROWS [18] = '{
    '{4'h1, 8'hFF, 8'h00, 8'h01, 4'h6, 8'h00, 8'h00},
    '{4'h1, 8'h7F, 8'h00, 8'h01, 4'h3, 8'h80, 8'h00},
    '{4'h2, 8'h0E, 8'h00, 8'h01, 4'hA, 8'h10, 8'h00},
    '{4'h1, 8'h12, 8'h00, 8'h21, 4'h0, 8'h33, 8'h00},
    '{4'h3, 8'h05, 8'h00, 8'h03, 4'hC, 8'h02, 8'h00},
    '{4'h3, 8'h03, 8'h00, 8'h05, 4'h8, 8'hFE, 8'h00},
    '{4'h3, 8'h80, 8'h00, 8'h01, 4'hD, 8'h7F, 8'h00},
    '{4'h3, 8'h05, 8'h00, 8'h03, 4'h4, 8'h01, 8'h00},
    '{4'h4, 8'h81, 8'h00, 8'h00, 4'h4, 8'h02, 8'h00},
    '{4'h5, 8'h01, 8'h00, 8'h00, 4'hC, 8'h80, 8'h00},
    '{4'h5, 8'h02, 8'h00, 8'h00, 4'h8, 8'h81, 8'h00},
    '{4'h6, 8'h05, 8'h00, 8'h05, 4'h4, 8'h05, 8'h00},
    '{4'h6, 8'h04, 8'h00, 8'h05, 4'h8, 8'h04, 8'h00},
    '{4'h7, 8'h10, 8'h20, 8'h00, 4'h1, 8'h00, 8'h02},
    '{4'h7, 8'h03, 8'h04, 8'h00, 4'h8, 8'h0C, 8'h00},
    '{4'h8, 8'h11, 8'h05, 8'h00, 4'h8, 8'h03, 8'h02},
    '{4'h8, 8'h11, 8'h00, 8'h00, 4'h9, 8'h11, 8'h00},
    '{4'hF, 8'h5A, 8'h00, 8'h00, 4'hC, 8'h5A, 8'h00}
  };
  // Sel, external flag and address of each data access.
  localparam logic [17:0] XT [5] = '{18'h3F000, 18'h3F03F, 18'h1F040,
    18'h0F005, 18'h1EFFF};

  csw_top i_dut (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(3'h2),
    .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .op_i(op_i),
    .xacc_i(xacc_i),
    .main_work_reg_o(main_work_reg_o),
    .opnd_o(opnd_o),
    .psw_o(psw_o),
    .bank_base_o(bank_base_o),
    .xsfr_sel_o(xsfr_sel_o),
    .xsfr_off_o(xsfr_off_o)
  );

  always #25 clock_i = ~clock_i;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
    input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // The slave may stall, so every phase waits for ready under a bound.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 20);
    if (hreadyout_o !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: bus stalled", $time);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] wd, output logic [31:0] rdata);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= wr;
    htrans_i <= `CSW_HTRANS_NONSEQ;
    wait_ready();
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_ready();
    rdata = hrdata_o;
    #1;
  endtask

  task automatic do_op(input logic [3:0] c, input logic [7:0] d);
    @(posedge clock_i);
    op_i <= '{vld: 1'b1, code: csw_pkg::csw_opc_t'(c), data: d};
    @(posedge clock_i);
    op_i <= '0;
    #1;
  endtask

  task automatic check_idle(input string what);
    check_byte(main_work_reg_o, 8'h00, what);
    check_byte(opnd_o, 8'h00, what);
    check_byte(psw_o, 8'h00, what);
    check_byte(bank_base_o, 8'h00, what);
    check_byte({7'h0, xsfr_sel_o}, 8'h00, what);
    check_byte({6'h0, hreadyout_o, hresp_o}, 8'h02, what);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock_i);
    num_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock_i);
    #1;
    check_idle("in reset");
    @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    bus(1'b0, `CSW_PSW_ADDR, 32'h0, rd);
    check_word(rd, 32'h0, "status reset");
    bus(1'b0, `CSW_OPND_ADDR, 32'h0, rd);
    check_word(rd, 32'h0, "operand reset");
    $display("test reset done");
    for (int i = 0; i < 18; i++) begin
      r = ROWS[i];
      do_op(4'h9, r.a);
      bus(1'b1, `CSW_OPND_ADDR, {24'h0, r.opn}, rd);
      bus(1'b1, `CSW_PSW_ADDR, {24'h0, r.f[3], 6'h00, ~^r.a}, rd);
      check_byte({7'h0, psw_o.parity}, {7'h0, ^r.a}, "wr parity");
      do_op(r.c, r.d);
      check_byte(main_work_reg_o, r.ea, "acc");
      check_byte(opnd_o, r.eb, "operand");
      check_byte({7'h0, psw_o.carry_out_flag}, {7'h0, r.f[2]}, "carry");
      check_byte({7'h0, psw_o.half_carry_flag}, {7'h0, r.f[1]}, "half");
      check_byte({7'h0, psw_o.signed_excess_flag}, {7'h0, r.f[0]}, "excess");
      check_byte({7'h0, psw_o.parity}, {7'h0, ^r.ea}, "parity");
    end
    $display("test op table done");
    for (int bk = 0; bk < 4; bk++) begin
      v = 8'h22 | 8'(bk << 3);
      bus(1'b1, `CSW_PSW_ADDR, {24'hFFFFFF, v}, rd);
      check_byte(bank_base_o, 8'(bk * 8), "bank base");
      bus(1'b0, `CSW_PSW_ADDR, 32'h0, rd);
      check_word(rd, {24'h0, v[7:1], ^8'h5A}, "status read");
    end
    $display("test bank and user flags done");
    bus(1'b1, `CSW_ACC_ADDR, 32'h07, rd);
    check_byte({7'h0, psw_o.parity}, 8'h01, "bus acc parity");
    bus(1'b0, `CSW_ACC_ADDR, 32'h0, rd);
    check_word(rd, 32'h0000_0007, "accumulator read");
    bus(1'b0, `CSW_PSW_ADDR, 32'h0, rd);
    check_word(rd, {24'h0, v[7:1], 1'b1}, "status parity read");
    bus(1'b1, 32'h0000_00C4, 32'hFF, rd);
    bus(1'b0, 32'h0000_00C4, 32'h0, rd);
    check_word(rd, 32'h0, "unmapped read");
    bus(1'b0, `CSW_OPND_ADDR, 32'h0, rd);
    check_word(rd, 32'h0, "operand kept");
    $display("test bus corners done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_i);
      xacc_i <= '{vld: 1'b1, external_move_op: XT[i][16], addr: XT[i][15:0]};
      @(posedge clock_i);
      xacc_i <= '0;
      #1;
      check_byte({7'h0, xsfr_sel_o}, {7'h0, XT[i][17]}, "window sel");
      if (XT[i][17]) begin
        check_byte({2'h0, xsfr_off_o}, {2'h0, XT[i][5:0]}, "offset");
      end
      @(posedge clock_i);
      #1;
      check_byte({7'h0, xsfr_sel_o}, 8'h00, "sel drops");
    end
    $display("test window done");
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    #1;
    check_idle("mid reset");
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    bus(1'b0, `CSW_PSW_ADDR, 32'h0, rd);
    check_word(rd, 32'h0, "status after mid reset");
    bus(1'b0, `CSW_OPND_ADDR, 32'h0, rd);
    check_word(rd, 32'h0, "operand after mid reset");
    $display("test mid reset done");
    print_verdict();
  end
endmodule

//--- hdl/csw_alu.sv
// Accumulator operations and the flags that each one produces.
`timescale 1ns/1ps
module csw_alu (
  input wire logic [7:0] acc_i,
  input wire logic [7:0] opnd_i,
  input wire logic carry_i,
  input wire logic half_i,
  input wire logic excess_i,
  input wire csw_pkg::csw_op_t op_i,
  output csw_pkg::csw_res_t res_o
);
  always_comb begin
    logic [8:0] sum;
    logic [4:0] half;
    logic [15:0] prod;
    logic cin;
    sum = 9'h000;
    half = 5'h00;
    prod = 16'h0000;
    cin = 1'b0;
    res_o.main_work_reg = acc_i;
    res_o.opnd = opnd_i;
    res_o.carry_out_flag = carry_i;
    res_o.half_carry_flag = half_i;
    res_o.signed_excess_flag = excess_i;
    unique case (op_i.code)
      csw_pkg::OP_ADD, csw_pkg::OP_ADDC: begin
        cin = (op_i.code == csw_pkg::OP_ADDC) & carry_i;
        sum = {1'b0, acc_i} + {1'b0, op_i.data} + {8'h00, cin};
        half = {1'b0, acc_i[3:0]} + {1'b0, op_i.data[3:0]} + {4'h0, cin};
        res_o.main_work_reg = sum[7:0];
        res_o.carry_out_flag = sum[8];
        res_o.half_carry_flag = half[4];
        res_o.signed_excess_flag = (acc_i[7] == op_i.data[7]) &&
                                   (sum[7] != acc_i[7]);
      end
      csw_pkg::OP_SUBB: begin
        // A clear carry means a borrow is still owed from before.
        cin = ~carry_i;
        sum = {1'b0, acc_i} - {1'b0, op_i.data} - {8'h00, cin};
        res_o.main_work_reg = sum[7:0];
        res_o.carry_out_flag = ~sum[8];
        res_o.signed_excess_flag = (acc_i[7] != op_i.data[7]) &&
                                   (sum[7] != acc_i[7]);
      end
      csw_pkg::OP_RLC: begin
        res_o.main_work_reg = {acc_i[6:0], carry_i};
        res_o.carry_out_flag = acc_i[7];
      end
      csw_pkg::OP_RRC: begin
        res_o.main_work_reg = {carry_i, acc_i[7:1]};
        res_o.carry_out_flag = acc_i[0];
      end
      csw_pkg::OP_CMP: begin
        res_o.carry_out_flag = (acc_i >= op_i.data);
      end
      csw_pkg::OP_MUL: begin
        prod = {8'h00, acc_i} * {8'h00, opnd_i};
        res_o.main_work_reg = prod[7:0];
        res_o.opnd = prod[15:8];
        res_o.carry_out_flag = 1'b0;
        res_o.signed_excess_flag = |prod[15:8];
      end
      csw_pkg::OP_DIV: begin
        // Division by zero leaves both operands as they were.
        res_o.carry_out_flag = 1'b0;
        res_o.signed_excess_flag = (opnd_i == 8'h00);
        if (opnd_i != 8'h00) begin
          res_o.main_work_reg = acc_i / opnd_i;
          res_o.opnd = acc_i % opnd_i;
        end
      end
      csw_pkg::OP_LOAD: begin
        res_o.main_work_reg = op_i.data;
      end
      csw_pkg::OP_NOP: begin
      end
      default: begin
      end
    endcase
  end
endmodule

//--- hdl/csw_defs.svh
// Addresses, reset values and bus codes of the status word block.
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CSW_PSW_ADDR 32'h0000_00D0
`define CSW_ACC_ADDR 32'h0000_00E0
`define CSW_OPND_ADDR 32'h0000_00F0

// ----------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------
`define CSW_BYTE_RST 8'h00
`define CSW_BANK_SHIFT 3
`define CSW_RD_PAD 24'h00_0000

// ----------------------------------------------------------------------
// External data space window of the peripheral registers
// ----------------------------------------------------------------------
`define CSW_XSFR_LO 16'hF000
`define CSW_XSFR_HI 16'hF03F
`define CSW_XOFF_W 6

// ----------------------------------------------------------------------
// Bus codes
// ----------------------------------------------------------------------
`define CSW_HTRANS_NONSEQ 2'b10
`define CSW_HRESP_OKAY 1'b0

`endif

//--- hdl/csw_parity.sv
// Odd parity of a data word, built as an exclusive-or chain.
`timescale 1ns/1ps
module csw_parity #(
  parameter int W = 8
) (
  input wire logic [W-1:0] data_i,
  output logic odd_o
);
  logic [W:0] chain;

  generate
    if (W < 1) begin : g_bad
      $error("csw_parity needs a width of at least one bit");
    end
  endgenerate

  assign chain[0] = 1'b0;
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      assign chain[i+1] = chain[i] ^ data_i[i];
    end
  endgenerate
  assign odd_o = chain[W];
endmodule

//--- hdl/csw_pkg.sv
// Types shared by the status word block and its helpers.
package csw_pkg;

  typedef enum logic [3:0] {
    OP_NOP  = 4'b0000,
    OP_ADD  = 4'b0001,
    OP_ADDC = 4'b0010,
    OP_SUBB = 4'b0011,
    OP_RLC  = 4'b0100,
    OP_RRC  = 4'b0101,
    OP_CMP  = 4'b0110,
    OP_MUL  = 4'b0111,
    OP_DIV  = 4'b1000,
    OP_LOAD = 4'b1001
  } csw_opc_t;

  typedef struct packed {
    logic vld;
    csw_opc_t code;
    logic [7:0] data;
  } csw_op_t;

  typedef struct packed {
    logic vld;
    logic external_move_op;
    logic [15:0] addr;
  } csw_xacc_t;

  typedef struct packed {
    logic carry_out_flag;
    logic half_carry_flag;
    logic user_flag_zero;
    logic [1:0] bank_select_field;
    logic signed_excess_flag;
    logic user_flag_one;
    logic parity;
  } csw_psw_t;

  typedef struct packed {
    logic [7:0] main_work_reg;
    logic [7:0] opnd;
    logic carry_out_flag;
    logic half_carry_flag;
    logic signed_excess_flag;
  } csw_res_t;

endpackage

//--- hdl/csw_top.sv
// Status word, accumulator and operand register behind an AHB-Lite slave.
//
// Function
// RL1 - Eight-bit operand register, zero at reset, feeds multiply and divide.
// RL2 - Carry bit 7: add carry, no borrow, rotated-out bit, compare >= 0.
// RL3 - Half-carry bit 6 follows the carry out of accumulator bit 3. Only add and add with carry set it; subtract with borrow leaves it unchanged.
// RL4 - Bank field bits 4..3 picks register bank base 00H, 08H, 10H, 18H.
// RL5 - Overflow bit 2 set on overflow of add, subtract, multiply or a divide by zero, cleared by those otherwise, kept by the other operations.
// RL6 - Read-only parity bit 0 is one for an odd count of ones.
// RL7 - Bits 5 and 1 are free user flags, writable, zero at reset.
// RL8 - Peripheral window in external space only reached by external moves.
// RL9 - Each accumulator operation updates its flags in the same instruction.
// RL10 - Software writes to the status word never change the parity bit.
`timescale 1ns/1ps
`include "csw_defs.svh"
module csw_top (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire csw_pkg::csw_op_t op_i,
  input wire csw_pkg::csw_xacc_t xacc_i,
  output logic [7:0] main_work_reg_o,
  output logic [7:0] opnd_o,
  output csw_pkg::csw_psw_t psw_o,
  output logic [7:0] bank_base_o,
  output logic xsfr_sel_o,
  output logic [`CSW_XOFF_W-1:0] xsfr_off_o
);
  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------------
  logic wr_ff;
  logic [31:0] waddr_ff;
  logic take;
  logic bus_psw;
  logic bus_acc;
  logic bus_opnd;

  // Only whole-word single transfers are expected, so hsize is not used.
  assign take = hsel_i && hready_i && (htrans_i == `CSW_HTRANS_NONSEQ);
  assign bus_psw = wr_ff && (waddr_ff == `CSW_PSW_ADDR);
  assign bus_acc = wr_ff && (waddr_ff == `CSW_ACC_ADDR);
  assign bus_opnd = wr_ff && (waddr_ff == `CSW_OPND_ADDR);

  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wr_ff <= 1'b0;
      waddr_ff <= 32'h0000_0000;
    end else begin
      wr_ff <= take && hwrite_i;
      waddr_ff <= haddr_i;
    end
  end

  // ----------------------------------------------------------------------
  // Next register values
  // ----------------------------------------------------------------------
  logic [7:0] acc_ff;
  logic [7:0] opnd_ff;
  csw_pkg::csw_psw_t psw_ff;
  csw_pkg::csw_res_t alu_res;
  logic [7:0] nxt_acc;
  logic [7:0] nxt_opnd;
  csw_pkg::csw_psw_t nxt_psw;
  logic nxt_par;

  csw_alu u_alu (
    .acc_i(acc_ff),
    .opnd_i(opnd_ff),
    .carry_i(psw_ff.carry_out_flag),
    .half_i(psw_ff.half_carry_flag),
    .excess_i(psw_ff.signed_excess_flag),
    .op_i(op_i),
    .res_o(alu_res)
  );

  // A core operation in the same cycle as a bus write wins, so a flag
  // the hardware produces is never lost to a stale software value.
  always_comb begin
    nxt_acc = acc_ff;
    nxt_opnd = opnd_ff;
    nxt_psw = psw_ff;
    if (bus_acc) begin
      nxt_acc = hwdata_i[7:0];
    end
    if (bus_opnd) begin
      nxt_opnd = hwdata_i[7:0]; // RL1
    end
    if (bus_psw) begin
      nxt_psw.carry_out_flag = hwdata_i[7];
      nxt_psw.half_carry_flag = hwdata_i[6];
      nxt_psw.user_flag_zero = hwdata_i[5]; // RL7
      nxt_psw.bank_select_field = hwdata_i[4:3];
      nxt_psw.signed_excess_flag = hwdata_i[2];
      nxt_psw.user_flag_one = hwdata_i[1]; // RL7
    end
    if (op_i.vld) begin
      nxt_acc = alu_res.main_work_reg;
      nxt_opnd = alu_res.opnd; // RL1
      nxt_psw.carry_out_flag = alu_res.carry_out_flag; // RL2 RL9
      nxt_psw.half_carry_flag = alu_res.half_carry_flag; // RL3 RL9
      nxt_psw.signed_excess_flag = alu_res.signed_excess_flag; // RL5 RL9
    end
    // Parity always follows the accumulator, whatever was written.
    nxt_psw.parity = nxt_par; // RL6 RL10
  end

  csw_parity #(
    .W(8)
  ) u_parity (
    .data_i(nxt_acc),
    .odd_o(nxt_par)
  );

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      acc_ff <= `CSW_BYTE_RST;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      opnd_ff <= `CSW_BYTE_RST; // RL1
    end else begin
      opnd_ff <= nxt_opnd;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      psw_ff <= `CSW_BYTE_RST;
    end else begin
      psw_ff <= nxt_psw;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bank_base_o <= `CSW_BYTE_RST;
    end else begin
      bank_base_o <= 8'(nxt_psw.bank_select_field) << `CSW_BANK_SHIFT; // RL4
    end
  end

  assign main_work_reg_o = acc_ff;
  assign opnd_o = opnd_ff;
  assign psw_o = psw_ff;

  // ----------------------------------------------------------------------
  // Bus data phase
  // ----------------------------------------------------------------------
  // Read data come from the next values, so a read right behind a write
  // or a core operation already sees the new contents.
  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      hrdata_o <= 32'h0000_0000;
    end else if (take && !hwrite_i) begin
      unique case (haddr_i)
        `CSW_PSW_ADDR: hrdata_o <= {`CSW_RD_PAD, nxt_psw};
        `CSW_ACC_ADDR: hrdata_o <= {`CSW_RD_PAD, nxt_acc};
        `CSW_OPND_ADDR: hrdata_o <= {`CSW_RD_PAD, nxt_opnd};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      hreadyout_o <= 1'b1;
      hresp_o <= `CSW_HRESP_OKAY;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= `CSW_HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------------
  // Peripheral window decode
  // ----------------------------------------------------------------------
  // Direct addressing never reaches the window, even with a matching
  // address; only an external move selects it.
  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      xsfr_sel_o <= 1'b0;
      xsfr_off_o <= '0;
    end else begin
      xsfr_sel_o <= xacc_i.vld && xacc_i.external_move_op &&
                    (xacc_i.addr >= `CSW_XSFR_LO) &&
                    (xacc_i.addr <= `CSW_XSFR_HI); // RL8
      xsfr_off_o <= xacc_i.addr[`CSW_XOFF_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_ff);

  logic [15:0] mul_prod;
  logic [8:0] add_sum;
  assign mul_prod = {8'h00, acc_ff} * {8'h00, opnd_ff};
  assign add_sum = {1'b0, acc_ff} + {1'b0, op_i.data};

  a_opnd_mul_high: assert property ( // RL1
    op_i.vld && op_i.code == csw_pkg::OP_MUL |=>
      opnd_ff == $past(mul_prod[15:8]) && acc_ff == $past(mul_prod[7:0]))
    else $error("operand register lost the product high byte");

  a_carry_add: assert property ( // RL2
    op_i.vld && op_i.code == csw_pkg::OP_ADD |=>
      psw_ff.carry_out_flag == $past(add_sum[8]))
    else $error("carry wrong after add");

  a_carry_cmp: assert property ( // RL2
    op_i.vld && op_i.code == csw_pkg::OP_CMP |=>
      psw_ff.carry_out_flag == ($past(acc_ff) >= $past(op_i.data)) &&
      $stable(acc_ff))
    else $error("carry wrong after compare");

  a_half_carry: assert property ( // RL3
    op_i.vld && op_i.code == csw_pkg::OP_ADD |=>
      psw_ff.half_carry_flag ==
      (({1'b0, $past(acc_ff[3:0])} + $past(op_i.data[3:0])) > 5'h0F))
    else $error("half carry wrong after add");

  a_bank_base: assert property ( // RL4
    bank_base_o == {3'b000, psw_ff.bank_select_field, 3'b000})
    else $error("bank base does not match bank field");

  a_ovf_mul: assert property ( // RL5
    op_i.vld && op_i.code == csw_pkg::OP_MUL |=>
      psw_ff.signed_excess_flag == $past(|mul_prod[15:8]))
    else $error("overflow wrong after multiply");

  a_parity_track: assert property ( // RL6
    psw_ff.parity == ^acc_ff)
    else $error("parity does not follow accumulator");

  a_user_flags: assert property ( // RL7
    bus_psw && !op_i.vld |=>
      psw_ff.user_flag_zero == $past(hwdata_i[5]) &&
      psw_ff.user_flag_one == $past(hwdata_i[1]))
    else $error("user flag write lost");

  a_xsfr_direct: assert property ( // RL8
    xacc_i.vld && !xacc_i.external_move_op |=> !xsfr_sel_o)
    else $error("window selected by direct access");

  a_load_parity: assert property ( // RL9
    op_i.vld && op_i.code == csw_pkg::OP_LOAD |=>
      psw_ff.parity == ^$past(op_i.data))
    else $error("parity not updated by the load");

  a_par_write: assert property ( // RL10
    bus_psw && !op_i.vld && !bus_acc |=> $stable(psw_ff.parity))
    else $error("status write changed parity");

  a_bus_ready: assert property (
    hreadyout_o && hresp_o == `CSW_HRESP_OKAY)
    else $error("slave stalled or erred");
endmodule
